//--- rtl/interrupt_timer_controller.v
// Interrupt controller, interval/loop/time-of-day timers and halt events
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_timer_controller_defs.vh"

module interrupt_timer_controller #(
  parameter LOOP_CYC = `LOOP_CYC,
  parameter IT_W     = 12,
  parameter TOD_W    = 36
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // External interrupt pins
  input  wire        io_finished_irq,
  input  wire        shared_mem_irq,
  input  wire        poll_request_irq,
  input  wire        extended_poll_request_irq,
  // Microinterrupt pins, see bit map of micro_cond
  input  wire [9:0]  micro_err,
  input  wire        shared_mem_alarm,
  // Sequencer events, same clock
  input  wire        end_of_operator,
  input  wire        mem_cycle_end,
  // Branch conditions to the sequencer
  output reg  [2:0]  group1_cond,
  output reg  [1:0]  group2_cond,
  output reg  [10:0] micro_cond,
  output reg         init_micro,
  // Halt and console
  output reg         clock_halt,
  output reg         full_stop,
  output reg         console_irq
);

  // ***********************************************************
  // Functions
  // ***********************************************************
  // Cause code of the latched microinterrupts; alarm ranks first
  function [3:0] micro_prio;
    input [10:0] v;
    integer i;
    begin
      micro_prio = `MI_NONE;
      for (i = 9; i >= 0; i = i - 1) begin
        if (v[i]) begin
          micro_prio = i[3:0];
        end
      end
      if (v[`MI_ALARM]) begin
        micro_prio = 4'ha;
      end
    end
  endfunction

  // Write strobe for one register offset during the data phase
  function wr_hit;
    input       pend;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      wr_hit = pend && (addr == ofs);
    end
  endfunction

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  reg  [14:0] sync1_r;
  reg  [14:0] sync2_r;
  wire [14:0] pins;

  assign pins = {shared_mem_alarm, micro_err, extended_poll_request_irq,
                 poll_request_irq, shared_mem_irq, io_finished_irq};

  // A pin reaches its pending flag three edges after it changes
  // Two stages; only the second stage feeds logic
  always @(posedge clk) begin
    if (rst) begin
      sync1_r <= 15'h0000;
      sync2_r <= 15'h0000;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  wire       iofin_s  = sync2_r[0];
  wire       shmem_s  = sync2_r[1];
  wire       poll_s   = sync2_r[2];
  wire       epoll_s  = sync2_r[3];
  wire [9:0] merr_s   = sync2_r[13:4];
  wire       alarm_s  = sync2_r[14];

  // ***********************************************************
  // AHB-Lite slave
  // ***********************************************************
  reg        wr_pend_r;
  reg  [5:0] wr_addr_r;
  reg  [4:0] ctrl_r;
  wire       addr_ok = hsel & htrans[1] & hready;
  wire       wr_en   = wr_pend_r;
  // One write strobe per writable register (none for groups or status), high in the write's data phase
  wire       wr_ctrl   = wr_hit(wr_en, wr_addr_r, `OFS_CTRL);
  wire       wr_itimer = wr_hit(wr_en, wr_addr_r, `OFS_ITIMER);
  wire       wr_cmd    = wr_hit(wr_en, wr_addr_r, `OFS_CMD);
  wire       wr_micro  = wr_hit(wr_en, wr_addr_r, `OFS_MICRO);
  wire       wr_tod_lo = wr_hit(wr_en, wr_addr_r, `OFS_TOD_LO);
  wire       wr_tod_hi = wr_hit(wr_en, wr_addr_r, `OFS_TOD_HI);
  wire [6:0] cmd     = wr_cmd ? hwdata[6:0] : 7'h00;
  wire       ack_g1  = cmd[`CMD_ACK_G1];
  wire       ack_g2  = cmd[`CMD_ACK_G2];

  // Transfer size is not decoded: every register is one whole word
  // Zero wait state; the slave is always ready and always OKAY
  always @(posedge clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 6'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      wr_addr_r <= haddr[5:0];
    end
  end

  // Control register; mask flop written only by the sequencer
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata[4:0];
    end
  end

  wire mask_ff = ctrl_r[`CTRL_MASK];
  wire ev_en   = ctrl_r[`CTRL_EV_EN];
  wire maint   = ctrl_r[`CTRL_MAINT];

  // ***********************************************************
  // Interval timer
  // ***********************************************************
  reg  [5:0]      it_div_r;
  reg  [IT_W-1:0] it_cnt_r;
  reg             it_armed_r;
  reg             it_fire_r;
  wire            it_tick = (it_div_r == `IT_TICK_CYC - 1);

  // Fixed timebase, free running so arming costs no extra phase
  always @(posedge clk) begin
    if (rst || it_tick) begin
      it_div_r <= 6'h00;
    end else begin
      it_div_r <= it_div_r + 6'h01;
    end
  end

  // Load arms; zero while armed fires and disarms
  // A load outranks an acknowledge, so software may re-arm in the same
  // command slot without losing the new count
  always @(posedge clk) begin
    it_fire_r <= 1'b0;
    if (rst) begin
      it_cnt_r   <= {IT_W{1'b0}};
      it_armed_r <= 1'b0;
    end else if (wr_itimer) begin
      it_cnt_r   <= hwdata[IT_W-1:0];
      it_armed_r <= 1'b1;
    end else if (ack_g1 || ack_g2) begin
      it_armed_r <= 1'b0;
    end else if (it_armed_r && it_tick) begin
      if (it_cnt_r == {IT_W{1'b0}}) begin
        it_fire_r  <= 1'b1;
        it_armed_r <= 1'b0;
      end else begin
        it_cnt_r <= it_cnt_r - {{(IT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ***********************************************************
  // Loop timer
  // ***********************************************************
  reg [31:0] lt_cnt_r;
  reg        lt_run_r;
  reg        lt_fire_r;

  // One-shot; frozen in maintenance mode so stepping never trips it
  // Restart outranks expiry, so a late operator end never lets a stale
  // expiry through
  always @(posedge clk) begin
    lt_fire_r <= 1'b0;
    if (rst) begin
      lt_cnt_r <= 32'h00000000;
      lt_run_r <= 1'b1;
    end else if (!maint) begin
      if (end_of_operator) begin
        lt_cnt_r <= 32'h00000000;
        lt_run_r <= 1'b1;
      end else if (lt_run_r) begin
        if (lt_cnt_r == LOOP_CYC - 1) begin
          lt_fire_r <= 1'b1;
          lt_run_r  <= 1'b0;
        end else begin
          lt_cnt_r <= lt_cnt_r + 32'h00000001;
        end
      end
    end
  end

  // ***********************************************************
  // Time-of-day counter
  // ***********************************************************
  reg [6:0]       tod_div_r;
  reg [TOD_W-1:0] tod_r;
  wire            tod_tick = (tod_div_r == `TOD_TICK_CYC - 1);

  // Console loads either half; counting wraps after 45 hours
  // A half load drops a tick that falls in the same cycle; one count of
  // slip per load is accepted to keep the loads simple
  always @(posedge clk) begin
    if (rst || tod_tick) begin
      tod_div_r <= 7'h00;
    end else begin
      tod_div_r <= tod_div_r + 7'h01;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tod_r <= {TOD_W{1'b0}};
    end else if (wr_tod_lo) begin
      tod_r[31:0] <= hwdata;
    end else if (wr_tod_hi) begin
      tod_r[TOD_W-1:32] <= hwdata[TOD_W-33:0];
    end else if (tod_tick) begin
      tod_r <= tod_r + {{(TOD_W-1){1'b0}}, 1'b1};
    end
  end

  // ***********************************************************
  // External interrupt groups
  // ***********************************************************
  reg  [2:0] g1_r;
  reg  [1:0] g2_r;
  wire [2:0] g1_set = {shmem_s, iofin_s, it_fire_r};
  wire [1:0] g2_set = {epoll_s, poll_s};

  // The mask acts at the output only, so the pending flags stay readable
  // A group clears as one; a new arrival wins over the clear
  always @(posedge clk) begin
    if (rst) begin
      g1_r        <= 3'h0;
      g2_r        <= 2'h0;
      group1_cond <= 3'h0;
      group2_cond <= 2'h0;
    end else begin
      g1_r        <= g1_set | (g1_r & {3{~ack_g1}});
      g2_r        <= g2_set | (g2_r & {2{~ack_g2}});
      group1_cond <= g1_r & {3{~mask_ff}};
      group2_cond <= g2_r;
    end
  end

  // ***********************************************************
  // Microinterrupts
  // ***********************************************************
  reg  [10:0] mi_r;
  wire [10:0] mi_set;
  wire [10:0] mi_clr;

  // Bit 3 is the loop timer; the pin in that slot is unused
  assign mi_set = {alarm_s, merr_s[9:4], lt_fire_r, merr_s[2:0]};
  assign mi_clr = wr_micro ? hwdata[10:0] : 11'h000;

  // The initiate line follows the latched flags, not the raw pins
  // Sticky until cleared, set wins so nothing slips through
  always @(posedge clk) begin
    if (rst) begin
      mi_r       <= 11'h000;
      micro_cond <= 11'h000;
      init_micro <= 1'b0;
    end else begin
      mi_r       <= mi_set | (mi_r & ~mi_clr);
      micro_cond <= mi_r;
      init_micro <= |mi_r;
    end
  end

  // ***********************************************************
  // Nesting counter and full stop
  // ***********************************************************
  reg [2:0] nest_r;

  // Entry counts up and saturates at the limit; the limit forces full stop
  always @(posedge clk) begin
    if (rst) begin
      nest_r      <= 3'h0;
      full_stop   <= 1'b0;
      console_irq <= 1'b0;
    end else begin
      if (cmd[`CMD_RETURN]) begin
        nest_r      <= 3'h0;
        console_irq <= 1'b0;
      end else if (cmd[`CMD_ENTRY] && nest_r != `NEST_LIMIT) begin
        nest_r <= nest_r + 3'h1;
      end
      if (nest_r == `NEST_LIMIT || cmd[`CMD_SH_SET]) begin
        full_stop <= 1'b1;
      end else if (cmd[`CMD_SH_CLR]) begin
        full_stop <= 1'b0;
      end
      // Return outranks the limit so the console line drops with the count
      if (nest_r == `NEST_LIMIT && !cmd[`CMD_RETURN]) begin
        console_irq <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // Maintenance events
  // ***********************************************************
  reg  halt_r;
  wire ev_eop  = end_of_operator & ~ctrl_r[`CTRL_EOP_MSK];
  wire ev_hold = mem_cycle_end & ~ctrl_r[`CTRL_HLD_MSK];

  // An event halt is sticky, so a one-cycle pulse still stops the clocks
  // Full stop bypasses masks and the enable
  always @(posedge clk) begin
    if (rst) begin
      halt_r     <= 1'b0;
      clock_halt <= 1'b0;
    end else begin
      if (ev_en && (ev_eop || ev_hold)) begin
        halt_r <= 1'b1;
      end else if (cmd[`CMD_HALT_CLR]) begin
        halt_r <= 1'b0;
      end
      clock_halt <= halt_r | full_stop;
    end
  end

  // ***********************************************************
  // Read data, captured in the address phase
  // ***********************************************************
  always @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[5:0])
        `OFS_CTRL:   hrdata <= {27'h0000000, ctrl_r};
        `OFS_ITIMER: hrdata <= {19'h00000, it_armed_r, it_cnt_r};
        `OFS_GROUPS: hrdata <= {27'h0000000, g2_r, g1_r};
        `OFS_MICRO:  hrdata <= {12'h000, micro_prio(mi_r), 5'h00, mi_r};
        `OFS_TOD_LO: hrdata <= tod_r[31:0];
        `OFS_TOD_HI: hrdata <= {28'h0000000, tod_r[TOD_W-1:32]};
        `OFS_STATUS: hrdata <= {25'h0000000, lt_run_r, halt_r, full_stop, nest_r, console_irq};
        // The command word holds only pulses and reads as zero
        default:     hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- rtl/interrupt_timer_controller_defs.vh
// Offsets, reset values and timing counts of the interrupt and timer block
// What this block does
// - Twelve-bit interval timer interrupts at zero, disarms
// - Any external acknowledge disarms the interval timer
// - Loop timer two-second one-shot, restarted by end_of_operator
// - Loadable 36-bit time_of_day_counter spans 45 hours
// - External interrupts in two groups, sampled/cleared together
// - Group one gated by normal/control mask
// - Group two poll requests never masked
// - Mask flop loaded only by sequencer write
// - Each microinterrupt latched in own flop
// - Any microinterrupt raises initiate-microinterrupt to fixed entry
// - Microinterrupt sources: parity, memory, address, loop, scan, bus
// - Shared-memory alarm wins simultaneous microinterrupts
// - Nesting counter increments on entry, clears on return
// - Nesting count five sets full stop, interrupts console
// - Console-selected events halt clocks only when enabled
// - end_of_operator event maskable by scan mask bit
// - Full-stop halt set by sequencer, never maskable
// - Memory-cycle hold event valid at cycle end, maskable
`ifndef INTERRUPT_TIMER_CONTROLLER_DEFS_VH
`define INTERRUPT_TIMER_CONTROLLER_DEFS_VH

// ***********************************************************
// Register byte offsets
// ***********************************************************
`define OFS_CTRL     6'h00
`define OFS_ITIMER   6'h04
`define OFS_CMD      6'h08
`define OFS_GROUPS   6'h0c
`define OFS_MICRO    6'h10
`define OFS_TOD_LO   6'h14
`define OFS_TOD_HI   6'h18
`define OFS_STATUS   6'h1c

// ***********************************************************
// Field positions
// ***********************************************************
`define CTRL_MASK    0
`define CTRL_EV_EN   1
`define CTRL_MAINT   2
`define CTRL_EOP_MSK 3
`define CTRL_HLD_MSK 4
`define CMD_ACK_G1   0
`define CMD_ACK_G2   1
`define CMD_ENTRY    2
`define CMD_RETURN   3
`define CMD_SH_SET   4
`define CMD_SH_CLR   5
`define CMD_HALT_CLR 6
`define MI_LOOP      3
`define MI_ALARM     10
`define MI_NONE      4'hf

// ***********************************************************
// Reset values and limits
// ***********************************************************
`define CTRL_RST     5'h01
`define NEST_LIMIT   3'h5

// ***********************************************************
// Timing
// ***********************************************************
`define CLK_NS       25
`define IT_TICK_NS   1000
`define IT_TICK_CYC  (`IT_TICK_NS / `CLK_NS)
// 45 hours over 2**36 counts is 2357 ns per count
`define TOD_TICK_NS  2357
`define TOD_TICK_CYC (`TOD_TICK_NS / `CLK_NS)
`define LOOP_MS      2000
`define LOOP_CYC     (`LOOP_MS * 40000)

`endif

//--- testbench/itc_checker_sva.sv
// Port-level checker for the interrupt and timer block
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_timer_controller_defs.vh"
// ****************************************
// Checker
// ****************************************
module itc_checker #(
  parameter LOOP_CYC = 200
) (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  // Pins and events
  input wire logic        poll_request_irq,
  input wire logic [9:0]  micro_err,
  input wire logic        shared_mem_alarm,
  input wire logic        end_of_operator,
  // Conditions and halt
  input wire logic [1:0]  group2_cond,
  input wire logic [10:0] micro_cond,
  input wire logic        init_micro,
  input wire logic        clock_halt,
  input wire logic        full_stop,
  input wire logic        console_irq
);
  logic mwr_r;
  int   cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Data phase of a clearing write; cycles since the last operator end
  always @(posedge clk) begin
    mwr_r <= hsel && htrans[1] && hready && hwrite && haddr[5:0] == `OFS_MICRO;
    cnt_r <= (rst || end_of_operator) ? 0 : cnt_r + 1;
  end
  a_ready_high: assert property (hreadyout)
    else $error("slave not ready");
  a_poll_open: assert property (poll_request_irq [*6] |-> group2_cond[0])
    else $error("poll condition missing");
  a_err_latch: assert property (micro_err[0] [*6] |-> micro_cond[0])
    else $error("error not latched");
  a_alarm_latch: assert property (shared_mem_alarm [*6] |-> micro_cond[10])
    else $error("alarm not latched");
  a_micro_hold: assert property (micro_cond[0] && !mwr_r && !$past(mwr_r) |=> micro_cond[0])
    else $error("latched error lost");
  a_init_on: assert property (micro_cond != 11'h0 && $past(micro_cond) != 11'h0 |-> init_micro)
    else $error("initiate missing");
  a_full_halt: assert property (full_stop && $past(full_stop) |-> clock_halt)
    else $error("full stop does not halt");
  a_stop_console: assert property ($rose(console_irq) |-> full_stop)
    else $error("console raised without full stop");
  a_loop_time: assert property ($rose(micro_cond[3]) |-> cnt_r >= LOOP_CYC - 2 && cnt_r <= LOOP_CYC + 3)
    else $error("loop expiry off time");
endmodule
bind interrupt_timer_controller itc_checker #(.LOOP_CYC(LOOP_CYC)) u_chk (
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .poll_request_irq, .micro_err,
  .shared_mem_alarm, .end_of_operator, .group2_cond, .micro_cond, .init_micro, .clock_halt,
  .full_stop, .console_irq);
`default_nettype wire

//--- testbench/seq_model.sv
// Sequencer-side model issuing operator-end and memory-cycle-end pulses
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  // Clock and requests
  input  wire logic clk,
  input  wire logic op_req,
  input  wire logic mem_req,
  // Event pulses
  output var  logic end_of_operator,
  output var  logic mem_cycle_end
);
  initial begin
    end_of_operator = 1'b0;
    mem_cycle_end = 1'b0;
  end
  // Each request copied one cycle later, held for as long as the request is held
  always @(posedge clk) begin
    end_of_operator <= op_req;
    mem_cycle_end <= mem_req;
  end
endmodule
`default_nettype wire

//--- testbench/test_interrupt_timer_controller.sv
// Self-checking bench for the interrupt and timer block
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_timer_controller_defs.vh"
// ****************************************
// Bench
// ****************************************
module test_interrupt_timer_controller;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  irq = 4'h0;
  logic [9:0]  micro_err = 10'h0;
  logic        alarm = 1'b0;
  logic        op_req = 1'b0;
  logic        mem_req = 1'b0;
  logic        rd_ph = 1'b0;
  logic [63:0] expq [$];
  logic [63:0] ent;
  logic [31:0] ev_ctrl [5] = '{32'h1, 32'h3, 32'hb, 32'h3, 32'h13};
  logic [4:0]  ev_halt = 5'b01010;
  int          errors = 0;
  int          checked = 0;
  int          seed = 60579;
  wire         hready;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, init_micro, clock_halt, full_stop, console_irq, eop, mce;
  wire  [2:0]  group1_cond;
  wire  [1:0]  group2_cond;
  wire  [10:0] micro_cond;

  always #12.5 clk = ~clk;
  assign hready = hreadyout;

  interrupt_timer_controller #(.LOOP_CYC(200)) u_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .io_finished_irq(irq[0]), .shared_mem_irq(irq[1]), .poll_request_irq(irq[2]),
    .extended_poll_request_irq(irq[3]), .micro_err(micro_err), .shared_mem_alarm(alarm),
    .end_of_operator(eop), .mem_cycle_end(mce), .group1_cond(group1_cond),
    .group2_cond(group2_cond), .micro_cond(micro_cond), .init_micro(init_micro),
    .clock_halt(clock_halt), .full_stop(full_stop), .console_irq(console_irq));
  seq_model u_seq (.clk(clk), .op_req(op_req), .mem_req(mem_req), .end_of_operator(eop), .mem_cycle_end(mce));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Single word transfer; reads note the masked expectation for the monitor
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {26'h0, a};
    hwrite <= w;
    if (!w) expq.push_back({m, d});
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      errors++;
      tally_and_finish;
    end
  endtask

  function automatic logic [3:0] low_idx(input logic [9:0] v);
    low_idx = 4'hf;
    for (int k = 9; k >= 0; k--)
      if (v[k]) low_idx = k[3:0];
  endfunction

  // Read data is taken at the edge closing the data phase
  always @(posedge clk) begin
    if (rd_ph && hreadyout === 1'b1 && expq.size() > 0) begin
      ent = expq.pop_front();
      chk(hrdata & ent[63:32], ent[31:0] & ent[63:32]);
      chk({31'h0, hresp}, 32'h0);
    end
    rd_ph <= hsel && htrans[1] && hready && !hwrite;
  end

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  initial begin
    int i;
    logic [9:0] e;
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `OFS_CTRL, 32'h1, '1);
    bus(1'b1, 6'h20, 32'hffffffff, 32'h0);
    bus(1'b0, 6'h20, 32'h0, '1);
    repeat (200) @(posedge clk);
    bus(1'b0, `OFS_MICRO, 32'h8, 32'h8);
    bus(1'b1, `OFS_MICRO, 32'h7ff, 32'h0);
    // Group one held back by the mask, group two never
    irq <= 4'hd;
    repeat (6) @(posedge clk);
    chk({27'h0, group2_cond, group1_cond}, 32'h18);
    bus(1'b0, `OFS_GROUPS, 32'h1a, '1);
    bus(1'b1, `OFS_CTRL, 32'h0, 32'h0);
    irq <= 4'h0;
    repeat (6) @(posedge clk);
    chk({27'h0, group2_cond, group1_cond}, 32'h1a);
    bus(1'b1, `OFS_CMD, 32'h3, 32'h0);
    bus(1'b0, `OFS_GROUPS, 32'h0, '1);
    // Interval timer expiry, then disarm by an acknowledge
    bus(1'b1, `OFS_ITIMER, 32'h2, 32'h0);
    bus(1'b0, `OFS_ITIMER, 32'h1000, 32'h1000);
    repeat (200) @(posedge clk);
    bus(1'b0, `OFS_ITIMER, 32'h0, '1);
    chk({29'h0, group1_cond}, 32'h1);
    bus(1'b1, `OFS_ITIMER, 32'h800, 32'h0);
    bus(1'b1, `OFS_CMD, 32'h2, 32'h0);
    bus(1'b0, `OFS_ITIMER, 32'h0, 32'h1000);
    // Nesting up to the limit, then return and release
    repeat (5) bus(1'b1, `OFS_CMD, 32'h4, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h1b, 32'h1f);
    chk({29'h0, full_stop, clock_halt, console_irq}, 32'h7);
    bus(1'b1, `OFS_CMD, 32'h8, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h10, 32'h1f);
    bus(1'b1, `OFS_CMD, 32'h20, 32'h0);
    repeat (2) @(posedge clk);
    chk({30'h0, full_stop, clock_halt}, 32'h0);
    // Microinterrupts, with and without the alarm alongside
    for (i = 0; i < 2; i++) begin
      e = ($random(seed) & 10'h3f7) | (i ? 10'h200 : 10'h001);
      micro_err <= e;
      alarm <= (i == 0);
      repeat (8) @(posedge clk);
      micro_err <= 10'h0;
      alarm <= 1'b0;
      repeat (6) @(posedge clk);
      chk({31'h0, init_micro}, 32'h1);
      bus(1'b0, `OFS_MICRO, {12'h0, i ? low_idx(e) : 4'ha, 5'h0, i == 0, e}, '1);
      bus(1'b1, `OFS_MICRO, 32'h7ff, 32'h0);
      bus(1'b0, `OFS_MICRO, 32'h000f0000, '1);
    end
    // Events: enable, operator-end mask, hold mask
    for (i = 0; i < 5; i++) begin
      bus(1'b1, `OFS_CTRL, ev_ctrl[i], 32'h0);
      op_req <= (i < 3);
      mem_req <= (i >= 3);
      @(posedge clk);
      op_req <= 1'b0;
      mem_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk({31'h0, clock_halt}, {31'h0, ev_halt[i]});
      bus(1'b0, `OFS_STATUS, {26'h0, ev_halt[i], 5'h0}, 32'h20);
      bus(1'b1, `OFS_CMD, 32'h40, 32'h0);
    end
    bus(1'b0, `OFS_MICRO, 32'h0, 32'h8);
    // Maintenance mode freezes the loop timer; an operator end restarts it
    bus(1'b1, `OFS_CTRL, 32'h4, 32'h0);
    repeat (250) @(posedge clk);
    bus(1'b0, `OFS_MICRO, 32'h0, 32'h8);
    bus(1'b1, `OFS_CTRL, 32'h0, 32'h0);
    op_req <= 1'b1;
    @(posedge clk);
    op_req <= 1'b0;
    // Time of day load and carry into the upper word
    r = $random(seed);
    r[15:0] = 16'h0;
    bus(1'b1, `OFS_TOD_LO, r, 32'h0);
    bus(1'b0, `OFS_TOD_LO, r, 32'hffff0000);
    bus(1'b1, `OFS_TOD_HI, 32'h3, 32'h0);
    bus(1'b1, `OFS_TOD_LO, 32'hffffffff, 32'h0);
    repeat (100) @(posedge clk);
    bus(1'b0, `OFS_TOD_HI, 32'h4, 32'hf);
    repeat (200) @(posedge clk);
    bus(1'b0, `OFS_MICRO, 32'h8, 32'h8);
    tally_and_finish;
  end
endmodule
`default_nettype wire
